// file: hdl/i2c_shift_addr_start_filter.sv
/*
 Slave byte shifter with bus stall, own-address compare and START
 filter, reached through SFR strobes.
 Assumes SDA and SCL pins are open drain with external pull-ups and
 that the status logic around it clears the flags on software request.
*/
`timescale 1ns/10ps
`include "i2c_saf_regs.svh"

module i2c_shift_addr_start_filter (
    input  wire logic                  core_clk,
    input  wire logic                  reset,
    input  wire i2c_saf_pkg::sfr_req_t sfrReq,
    output logic [7:0]                 sfrRdData,
    input  wire logic                  sdaIn,
    input  wire logic                  sclIn,
    output logic                       sdaOut,
    output logic                       sdaOe,
    output logic                       sclOut,
    output logic                       sclOe,
    input  wire logic                  slaveEnable,
    input  wire logic                  ackEnable,
    input  wire logic                  doneClear,
    input  wire logic                  matchClear,
    output logic                       doneFlag,
    output logic                       addrMatch,
    output logic                       txMode
);
    i2c_saf_pkg::link_state_t state;
    logic       sdaMeta, sdaS, sdaPrev;
    logic       sclMeta, sclS, sclPrev;
    logic       sclRise, sclFall, stopSeen, live;
    logic       startOk, startBad;
    logic [7:0] setupReg, dataReg, shiftReg;
    logic [6:0] ownIdReg;
    logic [3:0] bitCnt;
    logic       addrPhase, txDir, ackStage;
    logic       idMatch, wrDat, rdDat, release_, doneSet, matchSet;
    logic       sdaNext;

    // one address decoder for reads and writes
    function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
        hit = (a == o);
    endfunction : hit

    // pins pass two flops before any logic looks at them
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            {sdaMeta, sdaS, sdaPrev} <= 3'h7;
            {sclMeta, sclS, sclPrev} <= 3'h7;
        end else begin
            {sdaMeta, sdaS, sdaPrev} <= {sdaIn, sdaMeta, sdaS};
            {sclMeta, sclS, sclPrev} <= {sclIn, sclMeta, sclS};
        end
    end

    assign sclRise  = sclS & ~sclPrev;
    assign sclFall  = ~sclS & sclPrev;
    assign stopSeen = sclS & sclPrev & sdaS & ~sdaPrev;
    assign live     = slaveEnable & ~stopSeen & ~startOk;
    assign idMatch  = (ownIdReg == shiftReg[7:1]);
    assign wrDat    = sfrReq.wr & hit(sfrReq.addr, `REG_SHIFT_BYTE);
    assign rdDat    = sfrReq.rd & hit(sfrReq.addr, `REG_SHIFT_BYTE);
    // stall ends by write when sending, by read when receiving
    assign release_ = (state == i2c_saf_pkg::LINK_STALL)
                    & (txDir ? wrDat : rdDat);
    assign doneSet  = live & (state == i2c_saf_pkg::LINK_ACK) & sclFall
                    & (~addrPhase | idMatch);
    assign matchSet = doneSet & addrPhase;

    i2c_start_filter u_filter (
        .core_clk (core_clk),
        .reset    (reset),
        .sdaS     (sdaS),
        .sclS     (sclS),
        .armed    (slaveEnable),
        .setup    (setupReg),
        .startOk  (startOk),
        .startBad (startBad)
    );

    // byte engine; a stop or disable always returns to idle
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            state     <= i2c_saf_pkg::LINK_IDLE;
            shiftReg  <= `RST_BYTE;
            bitCnt    <= 4'h0;
            addrPhase <= 1'b0;
            txDir     <= 1'b0;
            ackStage  <= 1'b1;
        end else if (!slaveEnable || stopSeen) begin
            state <= i2c_saf_pkg::LINK_IDLE;
        end else if (startOk) begin
            state     <= i2c_saf_pkg::LINK_SHIFT;
            bitCnt    <= 4'h0;
            addrPhase <= 1'b1;
            txDir     <= 1'b0;
        end else begin
            case (state)
                i2c_saf_pkg::LINK_SHIFT: begin
                    if (sclRise && bitCnt != `BYTE_BITS) begin
                        bitCnt <= bitCnt + 4'h1;
                        if (!txDir) begin
                            shiftReg <= {shiftReg[6:0], sdaS};
                        end
                    end else if (sclFall && bitCnt == `BYTE_BITS) begin
                        state <= i2c_saf_pkg::LINK_ACK;
                        if (addrPhase && idMatch) begin
                            txDir <= shiftReg[0];
                        end
                    end else if (sclFall && txDir) begin
                        shiftReg <= {shiftReg[6:0], 1'b1};
                    end
                end
                i2c_saf_pkg::LINK_ACK: begin
                    if (sclRise) begin
                        ackStage <= sdaS;
                    end
                    if (sclFall) begin
                        state <= (addrPhase && !idMatch)
                               ? i2c_saf_pkg::LINK_IDLE
                               : i2c_saf_pkg::LINK_STALL;
                    end
                end
                i2c_saf_pkg::LINK_STALL: begin
                    if (release_) begin
                        state     <= i2c_saf_pkg::LINK_SHIFT;
                        bitCnt    <= 4'h0;
                        addrPhase <= 1'b0;
                        if (txDir) begin
                            shiftReg <= sfrReq.wdata;
                        end
                    end
                end
                default: state <= i2c_saf_pkg::LINK_IDLE;
            endcase
        end
    end

    // registers; received byte lands at end of its eighth bit
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            setupReg <= `RST_BYTE;
            dataReg  <= `RST_BYTE;
            ownIdReg <= 7'h00;
        end else begin
            if (sfrReq.wr && hit(sfrReq.addr, `REG_START_SETUP)) begin
                setupReg <= sfrReq.wdata;
            end
            if (sfrReq.wr && hit(sfrReq.addr, `REG_OWN_ID)) begin
                ownIdReg <= sfrReq.wdata[7:1];
            end
            if (wrDat) begin
                dataReg <= sfrReq.wdata;
            end else if (state == i2c_saf_pkg::LINK_SHIFT && sclFall
                         && bitCnt == `BYTE_BITS && !txDir) begin
                dataReg <= shiftReg;
            end
        end
    end

    // read data is held until the next read strobe
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            sfrRdData <= `RST_BYTE;
        end else if (sfrReq.rd) begin
            if (hit(sfrReq.addr, `REG_START_SETUP)) begin
                sfrRdData <= setupReg;
            end else if (rdDat) begin
                sfrRdData <= dataReg;
            end else if (hit(sfrReq.addr, `REG_OWN_ID)) begin
                sfrRdData <= {ownIdReg, 1'b0};
            end else begin
                sfrRdData <= `RST_BYTE;
            end
        end
    end

    // flags: a set in the clearing cycle wins
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            doneFlag  <= 1'b0;
            addrMatch <= 1'b0;
        end else begin
            doneFlag  <= doneSet | (doneFlag & ~doneClear);
            addrMatch <= matchSet | (addrMatch & ~matchClear);
        end
    end

    // SDA drive: data bit when sending, ack when receiving
    always_comb begin
        sdaNext = 1'b0;
        case (state)
            i2c_saf_pkg::LINK_SHIFT: sdaNext = txDir & ~shiftReg[7];
            i2c_saf_pkg::LINK_ACK:   sdaNext = ackEnable
                & (addrPhase ? idMatch : ~txDir);
            default:                 sdaNext = 1'b0;
        endcase
    end

    // one clock of pin latency is negligible next to SCL periods
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            sdaOe <= 1'b0;
            sclOe <= 1'b0;
        end else begin
            sdaOe <= sdaNext;
            sclOe <= (state == i2c_saf_pkg::LINK_STALL);
        end
    end

    assign sdaOut = 1'b0;
    assign sclOut = 1'b0;
    assign txMode = txDir;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);

    msb_first_a: assert property (
        (state == i2c_saf_pkg::LINK_STALL && txDir && wrDat && live)
        |=> ##1 (sdaOe == ~$past(sfrReq.wdata[7], 2)))
        else $error("first sent bit is not the msb");

    done_stall_a: assert property (
        $rose(doneFlag) |-> state == i2c_saf_pkg::LINK_STALL)
        else $error("done flag rose without a bus stall");

    stall_hold_a: assert property (
        state == i2c_saf_pkg::LINK_STALL |=> sclOe)
        else $error("scl not held low during stall");

    tx_release_a: assert property (
        (state == i2c_saf_pkg::LINK_STALL && txDir && wrDat && live)
        |=> state == i2c_saf_pkg::LINK_SHIFT ##1 !sclOe)
        else $error("write did not release transmit stall");

    rx_release_a: assert property (
        (state == i2c_saf_pkg::LINK_STALL && !txDir && rdDat && live)
        |=> state == i2c_saf_pkg::LINK_SHIFT ##1 !sclOe)
        else $error("read did not release receive stall");

    id_bit0_a: assert property (
        (sfrReq.rd && hit(sfrReq.addr, `REG_OWN_ID)) |=> !sfrRdData[0])
        else $error("own id bit zero not read as zero");

    match_done_a: assert property (
        $rose(addrMatch) |-> (doneFlag && txDir == $past(shiftReg[0])))
        else $error("address match without done flag");

    start_recv_a: assert property (
        (startOk && slaveEnable && !stopSeen)
        |=> (state == i2c_saf_pkg::LINK_SHIFT && bitCnt == 4'h0))
        else $error("valid start did not begin address byte");

    ack_drive_a: assert property (
        (state == i2c_saf_pkg::LINK_ACK && addrPhase && idMatch
         && ackEnable) |=> sdaOe)
        else $error("own address not acknowledged");

endmodule : i2c_shift_addr_start_filter

// file: hdl/i2c_saf_regs.svh
/*
 Register offsets, field positions, reset values and counts for the
 I2C shift, own-address and START filter block.
 Assumes it is included by bare name from the design files.
*/
`ifndef I2C_SAF_REGS_SVH
`define I2C_SAF_REGS_SVH

`define REG_START_SETUP 8'hDB
`define REG_SHIFT_BYTE  8'hDE
`define REG_OWN_ID      8'hDF
`define RST_BYTE        8'h00
`define SETUP_EXT_BIT   7
`define BYTE_BITS       4'h8
`define SAMPLE_ONE      8'h01

`endif

// file: hdl/i2c_saf_pkg.sv
/*
 Shared types of the I2C shift, own-address and START filter block.
 Assumes no other package.
*/
package i2c_saf_pkg;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } sfr_req_t;

    typedef enum logic [1:0] {
        LINK_IDLE,
        LINK_SHIFT,
        LINK_ACK,
        LINK_STALL
    } link_state_t;

    typedef enum logic {
        FILT_IDLE,
        FILT_SAMPLE
    } filt_state_t;

endpackage : i2c_saf_pkg

// file: hdl/i2c_start_filter.sv
/*
 START condition sampling filter.
 Assumes sdaS and sclS are already synchronised to core_clk.
*/
`timescale 1ns/10ps
`include "i2c_saf_regs.svh"

module i2c_start_filter (
    input  wire logic       core_clk,
    input  wire logic       reset,
    input  wire logic       sdaS,
    input  wire logic       sclS,
    input  wire logic       armed,
    input  wire logic [7:0] setup,
    output logic            startOk,
    output logic            startBad
);
    i2c_saf_pkg::filt_state_t state;
    logic       sdaPrev;
    logic [7:0] left_reg;
    logic [7:0] total;
    logic [7:0] taken_reg;
    logic [7:0] totalHeld;
    logic       fallSeen;
    logic       badSample;

    // falling SDA while SCL high opens a candidate
    assign fallSeen  = armed & sclS & sdaPrev & ~sdaS;
    assign badSample = sdaS | ~sclS;
    // sample count from the setup byte
    assign total = setup[`SETUP_EXT_BIT]
                 ? ({1'b0, setup[6:0]} + 8'h01)
                 : `SAMPLE_ONE;

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            sdaPrev <= 1'b1;
        end else begin
            sdaPrev <= sdaS;
        end
    end

    // one sample per clock, so spacing is one oscillator period
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            state    <= i2c_saf_pkg::FILT_IDLE;
            left_reg <= `RST_BYTE;
            startOk  <= 1'b0;
            startBad <= 1'b0;
        end else begin
            startOk  <= 1'b0;
            startBad <= 1'b0;
            if (!armed) begin
                state <= i2c_saf_pkg::FILT_IDLE;
            end else begin
                case (state)
                    i2c_saf_pkg::FILT_IDLE: begin
                        if (fallSeen) begin
                            state    <= i2c_saf_pkg::FILT_SAMPLE;
                            left_reg <= total;
                        end
                    end
                    i2c_saf_pkg::FILT_SAMPLE: begin
                        if (badSample) begin
                            startBad <= 1'b1;
                            state    <= i2c_saf_pkg::FILT_IDLE;
                        end else if (left_reg == 8'h01) begin
                            startOk <= 1'b1;
                            state   <= i2c_saf_pkg::FILT_IDLE;
                        end else begin
                            left_reg <= left_reg - 8'h01;
                        end
                    end
                    default: state <= i2c_saf_pkg::FILT_IDLE;
                endcase
            end
        end
    end

    // helper: samples taken in the current candidate
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            taken_reg <= `RST_BYTE;
            totalHeld <= `RST_BYTE;
        end else begin
            if (state == i2c_saf_pkg::FILT_SAMPLE) begin
                taken_reg <= taken_reg + 8'h01;
            end else begin
                taken_reg <= `RST_BYTE;
            end
            if (state == i2c_saf_pkg::FILT_IDLE && fallSeen) begin
                totalHeld <= total;
            end
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);

    single_sample_a: assert property (
        (armed && fallSeen && state == i2c_saf_pkg::FILT_IDLE
         && !setup[`SETUP_EXT_BIT]) |-> ##2 (startOk || startBad))
        else $error("single sample result not two cycles after edge");

    sample_count_a: assert property (
        startOk |-> (taken_reg == totalHeld))
        else $error("start validated after wrong number of samples");

    sample_spacing_a: assert property (
        (armed && state == i2c_saf_pkg::FILT_SAMPLE && !badSample
         && left_reg > 8'h01) |=> state == i2c_saf_pkg::FILT_SAMPLE)
        else $error("start samples not one clock apart");

    bad_reject_a: assert property (
        (armed && state == i2c_saf_pkg::FILT_SAMPLE && badSample)
        |=> (startBad && !startOk && state == i2c_saf_pkg::FILT_IDLE))
        else $error("bad start sample not rejected");

endmodule : i2c_start_filter

// file: sim/i2c_master_model.sv
/*
 Behavioural I2C master on the far side of the slave block.
 Assumes the bench resolves both open-drain lines with pull-ups.
*/
`timescale 1ns/10ps

module i2c_master_model (
    input  wire logic core_clk,
    input  wire logic sclLine,
    input  wire logic sdaLine,
    output logic      sclLow,
    output logic      sdaLow,
    output logic      stuck
);
    localparam int HALF = 8;

    // released lines at start, pull-ups give idle high
    initial begin
        sclLow = 1'h0;
        sdaLow = 1'h0;
        stuck  = 1'h0;
    end

    // all line changes land just after a clock edge
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : tick

    // SDA falls while SCL high, held hold clocks
    task automatic start_cond(input int hold);
        sdaLow = 1'h1;
        tick(hold);
        sclLow = 1'h1;
        tick(HALF);
    endtask : start_cond

    // noise dip on SDA too short to be a START, then SCL low
    task automatic glitch(input int len);
        sdaLow = 1'h1;
        tick(len);
        sdaLow = 1'h0;
        tick(HALF);
        sclLow = 1'h1;
        tick(HALF);
    endtask : glitch

    // one bit; a held SCL stalls us, bounded so a hang is seen
    task automatic clock_bit(input logic b, output logic got);
        int n;
        n = 0;
        sdaLow = ~b;
        tick(HALF);
        sclLow = 1'h0;
        while (sclLine !== 1'h1 && n < 4000) begin
            tick(1);
            n++;
        end
        if (n == 4000) stuck = 1'h1;
        tick(HALF);
        got = sdaLine;
        sclLow = 1'h1;
    endtask : clock_bit

    // eight bits MSB first, then the ack bit
    task automatic xfer(input logic [7:0] tx, input logic ackOut,
                        output logic [7:0] rx, output logic ack);
        for (int i = 7; i >= 0; i--) clock_bit(tx[i], rx[i]);
        clock_bit(~ackOut, ack);
    endtask : xfer

    // SDA rises while SCL high
    task automatic stop_cond();
        sdaLow = 1'h1;
        tick(HALF);
        sclLow = 1'h0;
        tick(HALF);
        sdaLow = 1'h0;
        tick(HALF);
    endtask : stop_cond
endmodule : i2c_master_model

// file: sim/test_i2c_shift_addr_start_filter.sv
/*
 Self-checking bench: SFR strobes plus a master model on the bus.
 Assumes the design and its register header compile first.
*/
`timescale 1ns/10ps
`include "i2c_saf_regs.svh"

module test_i2c_shift_addr_start_filter;
    logic                  core_clk    = 1'h0;
    logic                  reset       = 1'h1;
    i2c_saf_pkg::sfr_req_t sfrReq      = '0;
    logic                  slaveEnable = 1'h1;
    logic                  ackEnable   = 1'h0;
    logic                  doneClear   = 1'h0;
    logic                  matchClear  = 1'h0;
    logic [7:0]            sfrRdData;
    logic                  sdaOut, sdaOe, sclOut, sclOe;
    logic                  doneFlag, addrMatch, txMode;
    logic                  sdaLow, sclLow, stuck;
    logic                  sdaLine, sclLine;
    int                    error_cnt   = 0;
    int                    check_count = 0;
    logic [7:0]            d, rx;
    logic                  a;
    logic [7:0]            setups[3] = '{8'h00, 8'h84, 8'hFF};
    int                    dips[3]   = '{1, 3, 100};

    // open drain with pull-ups: low if anyone drives low
    assign sdaLine = ~((sdaOe & ~sdaOut) | sdaLow);
    assign sclLine = ~((sclOe & ~sclOut) | sclLow);

    always #12.5 core_clk = ~core_clk;

    i2c_shift_addr_start_filter dut (
        .core_clk(core_clk), .reset(reset), .sfrReq(sfrReq),
        .sfrRdData(sfrRdData), .sdaIn(sdaLine), .sclIn(sclLine),
        .sdaOut(sdaOut), .sdaOe(sdaOe), .sclOut(sclOut), .sclOe(sclOe),
        .slaveEnable(slaveEnable), .ackEnable(ackEnable),
        .doneClear(doneClear), .matchClear(matchClear),
        .doneFlag(doneFlag), .addrMatch(addrMatch), .txMode(txMode));

    i2c_master_model mdl (
        .core_clk(core_clk), .sclLine(sclLine), .sdaLine(sdaLine),
        .sclLow(sclLow), .sdaLow(sdaLow), .stuck(stuck));

    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : tick

    task automatic check(input logic [7:0] got, exp, input string what);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: %s got %h exp %h",
                     $time, what, got, exp);
        end
    endtask : check

    // one-cycle strobes, fields held until the taking edge
    task automatic sfr_wr(input logic [7:0] ad, dt);
        sfrReq = '{wr: 1'h1, rd: 1'h0, addr: ad, wdata: dt};
        tick(1);
        sfrReq = '0;
        // idle edge, so a following strobe never lands in this step
        tick(1);
    endtask : sfr_wr

    task automatic sfr_rd(input logic [7:0] ad, output logic [7:0] dt);
        sfrReq = '{wr: 1'h0, rd: 1'h1, addr: ad, wdata: 8'h00};
        tick(1);
        sfrReq = '0;
        tick(1);
        dt = sfrRdData;
    endtask : sfr_rd

    // bounded wait for the done flag, then compare it
    task automatic wait_done(input logic exp);
        int n;
        n = 0;
        while (doneFlag !== 1'h1 && n < 20) begin
            tick(1);
            n++;
        end
        check({7'h00, doneFlag}, {7'h00, exp}, "done flag");
        // sclOe is registered one clock behind the done flag
        tick(1);
        if (exp) check({7'h00, sclOe}, 8'h01, "scl stall");
    endtask : wait_done

    // software clears both sticky flags itself
    task automatic clr();
        doneClear  = 1'h1;
        matchClear = 1'h1;
        tick(1);
        doneClear  = 1'h0;
        matchClear = 1'h0;
    endtask : clr

    // receive side service: read the byte, stall must lift
    task automatic serve_rx(input logic [7:0] exp, input logic expAck);
        check({7'h00, a}, {7'h00, expAck}, "ack bit");
        wait_done(1'h1);
        sfr_rd(`REG_SHIFT_BYTE, d);
        check(d, exp, "rx byte");
        tick(1);
        check({7'h00, sclOe}, 8'h00, "rx release");
    endtask : serve_rx

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : give_verdict

    // watchdog, far beyond the few thousand cycles the tests need
    initial begin
        repeat (30000) @(posedge core_clk);
        error_cnt++;
        $display("mismatch at %0t: watchdog expired", $time);
        give_verdict();
    end

    initial begin
        repeat (20) @(posedge core_clk);
        #1;
        reset = 1'h0;
        tick(3);
        // reset values, unused id bit, unmapped place
        sfr_rd(`REG_START_SETUP, d);
        check(d, `RST_BYTE, "setup reset");
        sfr_rd(`REG_SHIFT_BYTE, d);
        check(d, `RST_BYTE, "shift reset");
        sfr_rd(`REG_OWN_ID, d);
        check(d, `RST_BYTE, "id reset");
        sfr_wr(8'hDC, 8'hFF);
        sfr_rd(8'hDC, d);
        check(d, 8'h00, "unmapped");
        sfr_wr(`REG_OWN_ID, 8'hB5);
        sfr_rd(`REG_OWN_ID, d);
        check(d, 8'hB4, "id bit0");
        ackEnable = 1'h1;
        $display("test registers done");

        // slave receive: address, acked byte, then unacked byte
        mdl.start_cond(10);
        mdl.xfer(8'hB4, 1'h0, rx, a);
        serve_rx(8'hB4, 1'h0);
        check({7'h00, addrMatch}, 8'h01, "match");
        check({7'h00, txMode}, 8'h00, "rx mode");
        clr();
        mdl.xfer(8'hC3, 1'h0, rx, a);
        serve_rx(8'hC3, 1'h0);
        clr();
        ackEnable = 1'h0;
        mdl.xfer(8'h3C, 1'h0, rx, a);
        serve_rx(8'h3C, 1'h1);
        clr();
        ackEnable = 1'h1;
        mdl.stop_cond();
        $display("test slave receive done");

        // slave transmit: a write of the shift byte lifts the stall
        mdl.start_cond(10);
        mdl.xfer(8'hB5, 1'h0, rx, a);
        check({7'h00, a}, 8'h00, "tx addr ack");
        wait_done(1'h1);
        check({7'h00, txMode}, 8'h01, "tx mode");
        clr();
        sfr_wr(`REG_SHIFT_BYTE, 8'h96);
        tick(1);
        check({7'h00, sclOe}, 8'h00, "tx release");
        mdl.xfer(8'hFF, 1'h0, rx, a);
        check(rx, 8'h96, "tx byte");
        wait_done(1'h1);
        clr();
        sfr_wr(`REG_SHIFT_BYTE, 8'hFF);
        mdl.stop_cond();
        $display("test slave transmit done");

        // foreign address: no ack, no done flag
        mdl.start_cond(10);
        mdl.xfer(8'hB6, 1'h0, rx, a);
        check({7'h00, a}, 8'h01, "foreign ack");
        wait_done(1'h0);
        mdl.stop_cond();
        $display("test foreign address done");

        // filter: short dip refused, long enough hold accepted
        for (int i = 0; i < 3; i++) begin
            sfr_wr(`REG_START_SETUP, setups[i]);
            mdl.glitch(dips[i]);
            mdl.xfer(8'hB4, 1'h0, rx, a);
            check({7'h00, a}, 8'h01, "noise start");
            wait_done(1'h0);
            mdl.stop_cond();
            mdl.start_cond(dips[i] + 40);
            mdl.xfer(8'hB4, 1'h0, rx, a);
            serve_rx(8'hB4, 1'h0);
            clr();
            mdl.stop_cond();
        end
        $display("test start filter done");
        check({7'h00, stuck}, 8'h00, "bus hang");
        give_verdict();
    end
endmodule : test_i2c_shift_addr_start_filter
